// file: hdl/ifr_pkg.sv
// Shared constants for the input function router: register map, reset values,
// digit codes, function indices and the absolute-clear hold time.
// Assumes a 200 MHz core clock and a 16-bit register port.
package ifr_pkg;

	// Register port widths
	localparam int DATA_W = 16;
	localparam int ADDR_W = 4;

	// Contacts, functions and assignment words
	localparam int NUM_CONTACTS = 10;
	localparam int NUM_FUNCS = 20;
	localparam int NUM_MAPS = 5;
	localparam int DIGIT_W = 4;
	localparam int DIGITS_PER_MAP = 4;
	localparam int POL_FIELD_W = 5;

	// Register offsets (word addresses on the plain port)
	localparam logic [ADDR_W-1:0] ADDR_MAP_A = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_MAP_B = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_MAP_C = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_MAP_D = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_MAP_E = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_POL_LOW = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_POL_HIGH = 4'h6;
	localparam logic [ADDR_W-1:0] ADDR_CONTACT_STAT = 4'h7;
	localparam logic [ADDR_W-1:0] ADDR_FUNC_STAT_LO = 4'h8;
	localparam logic [ADDR_W-1:0] ADDR_FUNC_STAT_HI = 4'h9;

	// Reset values of the assignment and polarity words
	localparam logic [DATA_W-1:0] MAP_RST [NUM_MAPS] = '{16'h4321, 16'h8765, 16'h00A9,
		16'h0000, 16'h0000};
	localparam logic [POL_FIELD_W-1:0] POL_RST = 5'h00;
	localparam logic [DATA_W-1:0] RDATA_IDLE = 16'h0000;

	// Assignment digit codes
	localparam logic [DIGIT_W-1:0] DIGIT_NONE = 4'h0;
	localparam logic [DIGIT_W-1:0] DIGIT_FIRST = 4'h1;
	localparam logic [DIGIT_W-1:0] DIGIT_LAST = 4'hA;
	localparam logic [DIGIT_W-1:0] DIGIT_ALWAYS = 4'hF;

	// Function positions in the function vector, map a digit 1 first
	localparam int FN_SERVO_ENABLE = 0;
	localparam int FN_SPEED_SELECT_BIT_ONE = 1;
	localparam int FN_SPEED_SELECT_BIT_TWO = 2;
	localparam int FN_SPEED_SELECT_BIT_THREE = 3;
	localparam int FN_ALARM_CLEAR = 4;
	localparam int FN_DIRECTION_SELECT = 5;
	localparam int FN_FORWARD_TRAVEL_BLOCK = 6;
	localparam int FN_REVERSE_TRAVEL_BLOCK = 7;
	localparam int FN_EMERGENCY_HALT = 8;
	localparam int FN_HALT = 9;
	localparam int FN_GEAR_SELECT_ONE = 10;
	localparam int FN_GEAR_SELECT_TWO = 11;
	localparam int FN_PROPORTIONAL_ONLY_CONTROL = 12;
	localparam int FN_SECOND_GAIN_SELECT = 13;
	localparam int FN_POSITION_ERROR_CLEAR = 14;
	localparam int FN_TORQUE_CAP = 15;
	localparam int FN_MODE_CHANGE = 16;
	localparam int FN_ABSOLUTE_POSITION_REQUEST = 17;
	localparam int FN_ZERO_HOLD = 18;
	localparam int FN_ABSOLUTE_POSITION_CLEAR = 19;

	// Absolute-clear hold time
	localparam int CLK_HZ = 200_000_000;
	localparam int ABS_CLEAR_HOLD_MS = 500;
	localparam int ABS_CLEAR_HOLD_CYCLES = (CLK_HZ / 1000) * ABS_CLEAR_HOLD_MS;
	localparam int ABS_CLEAR_CNT_W = 27;

endpackage

// file: hdl/ifr_digit_sel.sv
// One assignment digit turned into the active level of one function.
// Assumes contacts already synchronised and corrected for polarity.
`timescale 1ns/1ps
module ifr_digit_sel
	import ifr_pkg::*;
(
	// Assignment digit
	input wire logic [DIGIT_W-1:0] i_digit,
	// Contact levels, active high
	input wire logic [NUM_CONTACTS-1:0] i_contact,
	// Function level
	output logic o_active
);

	// Digit decode; unused codes B to E behave as unassigned
	always_comb begin
		o_active = 1'b0;
		if (i_digit == DIGIT_ALWAYS) begin
			o_active = 1'b1;
		end else if (i_digit >= DIGIT_FIRST && i_digit <= DIGIT_LAST) begin
			o_active = i_contact[i_digit - DIGIT_FIRST];
		end else begin
			o_active = 1'b0;
		end
	end

endmodule

// file: hdl/ifr_router.sv
// Input function router: ten contacts routed onto twenty drive functions.
// Assumes a plain register port on the core clock and contacts from pins.
// Notes on behaviour
// - Each function's contact comes from one digit of the five assignment words.
// - Contact polarity comes from two polarity words kept apart from the maps.
// - Map a routes servo enable and speed bits, map b alarm clear to reverse block.
// - Maps c, d and e route halts, gears, gain, error clear, torque, mode and abs.
// - A zero digit leaves its function unassigned and inactive.
// - Absolute clear fires only after its input stays high for 500 ms.
// - Digits 1 to A route the first to the tenth contact.
// - One contact may drive several functions at once.
// - A change to any assignment acts at once, with no commit step.
`timescale 1ns/1ps
module ifr_router
	import ifr_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = ABS_CLEAR_HOLD_CYCLES,
	parameter int unsigned HOLD_W = ABS_CLEAR_CNT_W
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	// Register port
	input wire logic [ADDR_W-1:0] i_reg_addr,
	input wire logic [DATA_W-1:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [DATA_W-1:0] o_reg_rdata,
	// Contact pins
	input wire logic [NUM_CONTACTS-1:0] i_contact,
	// Function levels and the absolute clear event
	output logic [NUM_FUNCS-1:0] o_function,
	output logic o_abs_clear_pulse
);

	// Elaboration checks on the hold counter
	if (HOLD_W < 2 || HOLD_W > 31) begin : g_bad_width
		$error("ifr_router: HOLD_W out of range");
	end
	if (HOLD_CYCLES < 1 || longint'(HOLD_CYCLES) >= (longint'(1) << HOLD_W)) begin : g_bad_hold
		$error("ifr_router: HOLD_CYCLES does not fit HOLD_W");
	end

	localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(HOLD_CYCLES - 1);
	localparam logic [HOLD_W-1:0] HOLD_FULL = HOLD_W'(HOLD_CYCLES);
	localparam logic [HOLD_W-1:0] HOLD_ONE = HOLD_W'(1);
	localparam logic [HOLD_W-1:0] HOLD_ZERO = '0;

	// Write strobe aimed at one address
	function automatic logic wr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] at);
		wr_hit = i_reg_wr && (addr == at);
	endfunction

	// Assignment words
	logic [DATA_W-1:0] map_q [NUM_MAPS];
	logic [DATA_W-1:0] map_d [NUM_MAPS];

	// Polarity words, only the low field is kept
	logic [POL_FIELD_W-1:0] pol_low_q;
	logic [POL_FIELD_W-1:0] pol_low_d;
	logic [POL_FIELD_W-1:0] pol_high_q;
	logic [POL_FIELD_W-1:0] pol_high_d;

	// Contact synchroniser and filter
	logic [NUM_CONTACTS-1:0] sync1_q;
	logic [NUM_CONTACTS-1:0] sync2_q;
	logic [NUM_CONTACTS-1:0] sync3_q;
	logic [NUM_CONTACTS-1:0] contact_q;
	logic [NUM_CONTACTS-1:0] contact_d;
	logic [NUM_CONTACTS-1:0] contact_active;

	// Routed functions
	logic [NUM_FUNCS-1:0] func_raw;
	logic [NUM_FUNCS-1:0] func_q;

	// Absolute clear hold counter
	logic [HOLD_W-1:0] hold_q;
	logic [HOLD_W-1:0] hold_d;
	logic abs_pulse_q;
	logic abs_pulse_d;

	// Read data
	logic [DATA_W-1:0] rdata_q;
	logic [DATA_W-1:0] rdata_d;

	// Next value of the assignment words; a write lands on the next edge
	always_comb begin
		map_d = map_q;
		for (int m = 0; m < NUM_MAPS; m++) begin
			if (wr_hit(i_reg_addr, ADDR_MAP_A + ADDR_W'(m))) begin
				map_d[m] = i_reg_wdata;
			end
		end
	end

	// Assignment word registers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			map_q <= MAP_RST;
		end else begin
			map_q <= map_d;
		end
	end

	// Next value of the polarity words
	always_comb begin
		pol_low_d = pol_low_q;
		pol_high_d = pol_high_q;
		if (wr_hit(i_reg_addr, ADDR_POL_LOW)) begin
			pol_low_d = i_reg_wdata[POL_FIELD_W-1:0];
		end
		if (wr_hit(i_reg_addr, ADDR_POL_HIGH)) begin
			pol_high_d = i_reg_wdata[POL_FIELD_W-1:0];
		end
	end

	// Polarity registers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			pol_low_q <= POL_RST;
			pol_high_q <= POL_RST;
		end else begin
			pol_low_q <= pol_low_d;
			pol_high_q <= pol_high_d;
		end
	end

	// Contact filter: a change counts only once stages two and three agree
	always_comb begin
		contact_d = (sync2_q & sync3_q) | (~(sync2_q | sync3_q) & 10'h000) |
			((sync2_q ^ sync3_q) & contact_q);
	end

	// Three-stage synchroniser on the pins; stage one feeds only stage two
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			sync1_q <= '0;
			sync2_q <= '0;
			sync3_q <= '0;
			contact_q <= '0;
		end else begin
			sync1_q <= i_contact;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
			contact_q <= contact_d;
		end
	end

	// Polarity: a set bit inverts its contact, contacts one to five in the low word
	assign contact_active = contact_q ^ {pol_high_q, pol_low_q};

	// One selector per function digit; any contact may feed several of them
	for (genvar f = 0; f < NUM_FUNCS; f++) begin : g_fn
		ifr_digit_sel u_sel (
			.i_digit(map_q[f / DIGITS_PER_MAP][(f % DIGITS_PER_MAP) * DIGIT_W +: DIGIT_W]),
			.i_contact(contact_active),
			.o_active(func_raw[f])
		);
	end

	// Function outputs registered; a map change shows one edge after the write
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			func_q <= '0;
		end else begin
			func_q <= func_raw;
		end
	end

	// Hold counter saturates, so one long press gives one clear event
	always_comb begin
		hold_d = hold_q;
		abs_pulse_d = 1'b0;
		if (!func_q[FN_ABSOLUTE_POSITION_CLEAR]) begin
			hold_d = HOLD_ZERO;
		end else if (hold_q != HOLD_FULL) begin
			hold_d = hold_q + HOLD_ONE;
			abs_pulse_d = (hold_q == HOLD_LAST);
		end
	end

	// Hold counter registers
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			hold_q <= HOLD_ZERO;
			abs_pulse_q <= 1'b0;
		end else begin
			hold_q <= hold_d;
			abs_pulse_q <= abs_pulse_d;
		end
	end

	// Read mux; data stand only in the cycle after the strobe, unmapped reads zero
	always_comb begin
		rdata_d = RDATA_IDLE;
		if (i_reg_rd) begin
			unique case (i_reg_addr)
				ADDR_MAP_A: rdata_d = map_q[0];
				ADDR_MAP_B: rdata_d = map_q[1];
				ADDR_MAP_C: rdata_d = map_q[2];
				ADDR_MAP_D: rdata_d = map_q[3];
				ADDR_MAP_E: rdata_d = map_q[4];
				ADDR_POL_LOW: rdata_d = DATA_W'(pol_low_q);
				ADDR_POL_HIGH: rdata_d = DATA_W'(pol_high_q);
				ADDR_CONTACT_STAT: rdata_d = DATA_W'(contact_q);
				ADDR_FUNC_STAT_LO: rdata_d = func_q[DATA_W-1:0];
				ADDR_FUNC_STAT_HI: rdata_d = DATA_W'(func_q[NUM_FUNCS-1:DATA_W]);
				default: rdata_d = RDATA_IDLE;
			endcase
		end
	end

	// Read data register
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_q <= RDATA_IDLE;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	// Outputs, all from flip-flops
	assign o_reg_rdata = rdata_q;
	assign o_function = func_q;
	assign o_abs_clear_pulse = abs_pulse_q;

endmodule

// file: bench/ifr_router_properties.sv
// Port checks for the input function router.
// Assumes only the router's ports; bound into every router instance.
`timescale 1ns/1ps
module ifr_router_properties
	import ifr_pkg::*;
#(
	parameter int unsigned HOLD_CYCLES = ABS_CLEAR_HOLD_CYCLES,
	parameter int unsigned HOLD_W = ABS_CLEAR_CNT_W
) (
	// Router ports
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_reg_addr,
	input wire logic [DATA_W-1:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	input wire logic [DATA_W-1:0] o_reg_rdata,
	input wire logic [NUM_CONTACTS-1:0] i_contact,
	input wire logic [NUM_FUNCS-1:0] o_function,
	input wire logic o_abs_clear_pulse
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	int unsigned run_q;
	int unsigned run_d;
	// High run of absolute clear; saturates so a long hold cannot wrap
	always_comb begin
		run_d = !o_function[FN_ABSOLUTE_POSITION_CLEAR] ? 0 :
			(run_q > HOLD_CYCLES ? run_q : run_q + 1);
	end
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) run_q <= 0;
		else run_q <= run_d;
	end
	property p_pulse_hold; o_abs_clear_pulse |-> run_q == HOLD_CYCLES; endproperty
	a_pulse_hold: assert property (p_pulse_hold) else $error("early clear pulse");
	property p_pulse_due; run_q == HOLD_CYCLES |-> o_abs_clear_pulse; endproperty
	a_pulse_due: assert property (p_pulse_due) else $error("missing clear pulse");
	property p_rd_idle; !$past(i_reg_rd) |-> o_reg_rdata == RDATA_IDLE; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_unmapped; i_reg_rd && i_reg_addr > ADDR_FUNC_STAT_HI |=> o_reg_rdata == 16'h0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_pol_read; i_reg_rd && (i_reg_addr == ADDR_POL_LOW || i_reg_addr == ADDR_POL_HIGH)
		|=> o_reg_rdata[15:5] == 11'h000; endproperty
	a_pol_read: assert property (p_pol_read) else $error("polarity spare bits set");
	property p_stat_read; i_reg_rd && i_reg_addr == ADDR_CONTACT_STAT
		|=> o_reg_rdata[15:10] == 6'h00; endproperty
	a_stat_read: assert property (p_stat_read) else $error("contact status too wide");
	property p_always_on; i_reg_wr && i_reg_addr == ADDR_MAP_D && i_reg_wdata[11:8] == 4'hF
		|-> ##2 o_function[14]; endproperty
	a_always_on: assert property (p_always_on) else $error("forced function off");
	property p_unassigned; i_reg_wr && i_reg_addr == ADDR_MAP_D && i_reg_wdata[15:12] == 4'h0
		|-> ##2 !o_function[15]; endproperty
	a_unassigned: assert property (p_unassigned) else $error("unassigned function on");
endmodule
bind ifr_router ifr_router_properties #(.HOLD_CYCLES(HOLD_CYCLES), .HOLD_W(HOLD_W)) i_props (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
	.i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_contact(i_contact),
	.o_function(o_function), .o_abs_clear_pulse(o_abs_clear_pulse));

// file: bench/ifr_contact_model.sv
// Switches on the contact pins.
// Assumes the bench sets the wanted levels; pins are always driven.
`timescale 1ns/1ps
module ifr_contact_model
	import ifr_pkg::*;
(
	// Wanted levels
	input wire logic [NUM_CONTACTS-1:0] i_level,
	// Contact pins
	output logic [NUM_CONTACTS-1:0] o_contact
);
	// Skewed 1.3 ns off the clock so pins change between edges, not on one; a level holds as long as asked
	initial o_contact = '0;
	always @(i_level) o_contact <= #1.3 i_level;
endmodule

// file: bench/test_ifr_router.sv
// Self-checking bench for the input function router.
// Assumes the router, its checker bind and the contact model.
`timescale 1ns/1ps
module test_ifr_router
	import ifr_pkg::*;
;
	localparam int unsigned HOLD = 8;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [NUM_CONTACTS-1:0] level = '0;
	logic [NUM_CONTACTS-1:0] contact;
	logic [DATA_W-1:0] rdata;
	logic [NUM_FUNCS-1:0] func;
	logic pulse;
	int n_fail = 0;
	int n_checks = 0;
	int n_pulse = 0;
	int i;
	// Short hold count keeps the run brief
	ifr_contact_model i_sw (.i_level(level), .o_contact(contact));
	ifr_router #(.HOLD_CYCLES(HOLD), .HOLD_W(4)) i_dut (.i_core_clk(clk), .i_rst(rst),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
		.o_reg_rdata(rdata), .i_contact(contact), .o_function(func), .o_abs_clear_pulse(pulse));
	initial forever #2.5 clk = ~clk;
	always @(posedge clk) if (pulse === 1'b1) n_pulse <= n_pulse + 1;
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk("rdata", {4'h0, exp}, {4'h0, rdata});
	endtask
	// Pin to function takes at most five cycles
	task automatic set_chk(input logic [9:0] lvl, input logic [19:0] exp);
		@(posedge clk);
		level <= lvl;
		repeat (8) @(posedge clk);
		#1 chk("func", exp, func);
	endtask
	task automatic count_until(input bit on_pulse, output int n);
		n = 0;
		while ((on_pulse ? pulse : func[19]) !== 1'b1) begin
			@(posedge clk);
			#1 n++;
			if (n > 50) begin
				n_fail++;
				end_of_test();
			end
		end
	endtask
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		wr_reg(4'hF, 16'hFFFF);
		for (i = 0; i < 5; i++) rd_chk(i[3:0], MAP_RST[i]);
		rd_chk(ADDR_POL_LOW, 16'h0000);
		rd_chk(ADDR_CONTACT_STAT, 16'h0000);
		rd_chk(4'hF, 16'h0000);
		for (i = 0; i < 10; i++) set_chk(10'h001 << i, 20'h00001 << i);
		wr_reg(ADDR_MAP_D, 16'h0F11);
		set_chk(10'h001, 20'h07001);
		set_chk(10'h000, 20'h04000);
		wr_reg(ADDR_POL_LOW, 16'hFFE1);
		rd_chk(ADDR_POL_LOW, 16'h0001);
		set_chk(10'h000, 20'h07001);
		wr_reg(ADDR_POL_LOW, 16'h0000);
		wr_reg(ADDR_MAP_D, 16'h0000);
		// Every digit place of maps c and e; odd and even contacts keep them apart
		wr_reg(ADDR_MAP_C, 16'h1234);
		wr_reg(ADDR_MAP_E, 16'h0765);
		set_chk(10'h055, 20'h50A55);
		set_chk(10'h0AA, 20'h205AA);
		rd_chk(ADDR_CONTACT_STAT, 16'h00AA);
		rd_chk(ADDR_FUNC_STAT_LO, 16'h05AA);
		rd_chk(ADDR_FUNC_STAT_HI, 16'h0002);
		// Upper polarity word inverts the seventh contact only
		wr_reg(ADDR_POL_HIGH, 16'hFFE2);
		rd_chk(ADDR_POL_HIGH, 16'h0002);
		set_chk(10'h0AA, 20'h605EA);
		set_chk(10'h000, 20'h40040);
		wr_reg(ADDR_POL_HIGH, 16'h0000);
		wr_reg(ADDR_MAP_E, 16'h2000);
		// Too short a hold must not clear
		@(posedge clk);
		level <= 10'h002;
		repeat (3) @(posedge clk);
		set_chk(10'h000, 20'h00000);
		@(posedge clk);
		level <= 10'h002;
		count_until(1'b0, i);
		count_until(1'b1, i);
		chk("hold", 20'(HOLD), 20'(i));
		set_chk(10'h000, 20'h00000);
		chk("pulses", 20'h00001, 20'(n_pulse));
		end_of_test();
	end
endmodule
